/* rtl/gts_timer_suite.sv */
// Purpose: Three 16-bit timers; the second and third may chain to 32 bits.
// Assumes: Pins may be asynchronous to clock; one clock at 100 MHz.
// Notes:   Each timer pin is both its external clock and its gate.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module gts_timer_suite
  import gts_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire gts_bus_s          bus,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              idle_mode,
  input  wire logic              first_ext_clock_pin,
  input  wire logic              second_ext_clock_pin,
  input  wire logic              third_ext_clock_pin,
  output logic                   first_irq,
  output logic                   second_irq,
  output logic                   third_irq,
  output logic                   adc_trigger,
  output logic      [DATA_W-1:0] second_time_base,
  output logic      [DATA_W-1:0] third_time_base
);

  gts_ctl_s          ctl     [NUM_TMR];
  gts_ctl_s          eff     [NUM_TMR];
  logic [DATA_W-1:0] cnt     [NUM_TMR];
  logic [DATA_W-1:0] per     [NUM_TMR];
  logic              pin     [NUM_TMR];
  logic              ctl_wr  [NUM_TMR];
  logic              s1      [NUM_TMR];
  logic              s2      [NUM_TMR];
  logic              s3      [NUM_TMR];
  logic              raw_q   [NUM_TMR];
  logic              raw_prev[NUM_TMR];
  logic [7:0]        pre     [NUM_TMR];
  logic [7:0]        pre_end [NUM_TMR];
  logic              run     [NUM_TMR];
  logic              cnt_in  [NUM_TMR];
  logic              tick    [NUM_TMR];
  logic              gate_on [NUM_TMR];
  logic              gate_fall[NUM_TMR];
  logic              match   [NUM_TMR];
  logic              chain;
  logic [31:0]       cnt32;
  logic [31:0]       per32;
  logic              match32;
  logic [31:0]       next_cnt32;

  // Decode the control fields from a write data word.
  function automatic gts_ctl_s unpack_ctl(input logic [15:0] d);
    gts_ctl_s c;
    c.run_enable             = d[BIT_RUN];
    c.idle_stop              = d[BIT_IDLE];
    c.gate_accumulate_enable = d[BIT_GATE];
    c.prescale_select        = d[BIT_PS_HI:BIT_PS_LO];
    c.chain_mode             = d[BIT_CHAIN];
    c.ext_clock_sync         = d[BIT_SYNC];
    c.clock_source_select    = d[BIT_CS];
    return c;
  endfunction : unpack_ctl

  // Place the control fields back at their bit positions.
  function automatic logic [15:0] pack_ctl(input gts_ctl_s c);
    logic [15:0] d;
    d = 16'h0000;
    d[BIT_RUN]             = c.run_enable;
    d[BIT_IDLE]            = c.idle_stop;
    d[BIT_GATE]            = c.gate_accumulate_enable;
    d[BIT_PS_HI:BIT_PS_LO] = c.prescale_select;
    d[BIT_CHAIN]           = c.chain_mode;
    d[BIT_SYNC]            = c.ext_clock_sync;
    d[BIT_CS]              = c.clock_source_select;
    return d;
  endfunction : pack_ctl

  // Terminal count of the prescaler for a divide selection.
  function automatic logic [7:0] ps_last(input logic [1:0] sel);
    logic [7:0] v;
    unique case (sel)
      2'h0: v = PS_LAST_1;
      2'h1: v = PS_LAST_8;
      2'h2: v = PS_LAST_64;
      2'h3: v = PS_LAST_256;
    endcase
    return v;
  endfunction : ps_last

  assign chain   = ctl[1].chain_mode;
  assign pin[0]  = first_ext_clock_pin;
  assign pin[1]  = second_ext_clock_pin;
  assign pin[2]  = third_ext_clock_pin;
  assign ctl_wr[0] = bus.wr && (bus.addr == ADDR_FIRST_CTL);
  assign ctl_wr[1] = bus.wr && (bus.addr == ADDR_SECOND_CTL);
  assign ctl_wr[2] = bus.wr && (bus.addr == ADDR_THIRD_CTL);

  // Control registers; unimplemented bits are never stored.
  // zero after reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      ctl[0] <= '0;
      ctl[1] <= '0;
      ctl[2] <= '0;
    end else if (clk_en) begin
      if (ctl_wr[0]) begin
        ctl[0] <= unpack_ctl(bus.wdata & MASK_FIRST);
      end
      if (ctl_wr[1]) begin
        ctl[1] <= unpack_ctl(bus.wdata & MASK_SECOND);
      end
      if (ctl_wr[2]) begin
        ctl[2] <= unpack_ctl(bus.wdata & MASK_THIRD);
      end
    end
  end

  // Period registers; all ones so a fresh timer runs the full range.
  always_ff @(posedge clock) begin
    if (rst) begin
      per[0] <= PER_RESET;
      per[1] <= PER_RESET;
      per[2] <= PER_RESET;
    end else if (clk_en && bus.wr) begin
      if (bus.addr == ADDR_FIRST_PER) begin
        per[0] <= bus.wdata;
      end
      if (bus.addr == ADDR_SECOND_PER) begin
        per[1] <= bus.wdata;
      end
      if (bus.addr == ADDR_THIRD_PER) begin
        per[2] <= bus.wdata;
      end
    end
  end

  // Per-timer clock selection, gating and prescaling.
  for (genvar i = 0; i < NUM_TMR; i++) begin : g_ch
    assign eff[i] = (i == 2 && chain) ? ctl[1] : ctl[i];

    // Two-stage synchroniser plus an edge history flop.
    always_ff @(posedge clock) begin
      if (rst) begin
        s1[i]       <= 1'b0;
        s2[i]       <= 1'b0;
        s3[i]       <= 1'b0;
        raw_q[i]    <= 1'b0;
        raw_prev[i] <= 1'b0;
      end else if (clk_en) begin
        s1[i]       <= pin[i];
        s2[i]       <= s1[i];
        s3[i]       <= s2[i];
        raw_q[i]    <= pin[i];
        raw_prev[i] <= raw_q[i];
      end
    end

    // idle stop, third bit joins when chained.
    // a clear run enable, or idle stop while idle_mode is high, halts the timer.
    assign run[i] = eff[i].run_enable && !(idle_mode &&
                    (eff[i].idle_stop ||
                     (i == 1 && chain && ctl[2].idle_stop)));

    // gate only honoured on the internal clock.
    assign gate_on[i] = eff[i].gate_accumulate_enable &&
                        !eff[i].clock_source_select;

    // only the first timer may skip the synchroniser.
    // the short path gives the faster async counter.
    assign cnt_in[i] = eff[i].clock_source_select ?
      ((i == 0 && !eff[i].ext_clock_sync) ?
         (raw_q[i] && !raw_prev[i]) : (s2[i] && !s3[i])) :
      (gate_on[i] ? s2[i] : 1'b1);

    assign pre_end[i]   = ps_last(eff[i].prescale_select);
    // one tick per full prescaler pass.
    assign tick[i]      = run[i] && cnt_in[i] && (pre[i] == pre_end[i]);
    assign gate_fall[i] = run[i] && gate_on[i] && s3[i] && !s2[i];
    assign match[i]     = (cnt[i] == per[i]);

    // Prescaler restarts on a control write so a new ratio is exact.
    always_ff @(posedge clock) begin
      if (rst) begin
        pre[i] <= 8'h00;
      end else if (clk_en) begin
        if (ctl_wr[i] || !run[i]) begin
          pre[i] <= 8'h00;
        end else if (cnt_in[i]) begin
          pre[i] <= (pre[i] == pre_end[i]) ? 8'h00 : pre[i] + 8'h01;
        end
      end
    end
  end

  assign per32   = {per[2], per[1]};
  // second low word, third high word.
  assign cnt32   = {cnt[2], cnt[1]};
  assign match32 = (cnt32 == per32);
  assign next_cnt32 = match32 ? 32'h0000_0000 : cnt32 + 32'h0000_0001;

  // First counter; a software write wins over a tick.
  // count only on ticks while running.
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt[0] <= CNT_RESET;
    end else if (clk_en) begin
      if (bus.wr && bus.addr == ADDR_FIRST_CNT) begin
        cnt[0] <= bus.wdata;
      end else if (tick[0]) begin
        cnt[0] <= match[0] ? CNT_RESET : cnt[0] + 16'h0001;
      end
    end
  end

  // Second and third counters, chained or independent.
  // chained count kept in the pair.
  // unchained halves tick on their own.
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt[1] <= CNT_RESET;
      cnt[2] <= CNT_RESET;
    end else if (clk_en) begin
      if (bus.wr && bus.addr == ADDR_SECOND_CNT) begin
        cnt[1] <= bus.wdata;
      end else if (chain ? tick[1] : tick[1]) begin
        cnt[1] <= chain ? next_cnt32[15:0] :
                  (match[1] ? CNT_RESET : cnt[1] + 16'h0001);
      end
      if (bus.wr && bus.addr == ADDR_THIRD_CNT) begin
        cnt[2] <= bus.wdata;
      end else if (chain ? tick[1] : tick[2]) begin
        cnt[2] <= chain ? next_cnt32[31:16] :
                  (match[2] ? CNT_RESET : cnt[2] + 16'h0001);
      end
    end
  end

  // Event outputs are registered, high for one cycle per event; events on back-to-back cycles hold them high.
  // match or gate fall.
  // chained events leave through the third flag.
  always_ff @(posedge clock) begin
    if (rst) begin
      first_irq   <= 1'b0;
      second_irq  <= 1'b0;
      third_irq   <= 1'b0;
      adc_trigger <= 1'b0;
    end else if (clk_en) begin
      first_irq   <= (tick[0] && match[0]) || gate_fall[0];
      second_irq  <= !chain && ((tick[1] && match[1]) || gate_fall[1]);
      third_irq   <= chain ? ((tick[1] && match32) || gate_fall[1]) :
                             ((tick[2] && match[2]) || gate_fall[2]);
      adc_trigger <= chain && tick[1] && match32;
    end
  end

  assign second_time_base = cnt[1];
  assign third_time_base  = cnt[2];

  // Read data stand in the cycle after the strobe only.
  // masked bits and unmapped words read zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else if (clk_en) begin
      rd_data <= 16'h0000;
      if (bus.rd) begin
        unique case (bus.addr)
          ADDR_FIRST_CTL:  rd_data <= pack_ctl(ctl[0]) & MASK_FIRST;
          ADDR_FIRST_CNT:  rd_data <= cnt[0];
          ADDR_FIRST_PER:  rd_data <= per[0];
          ADDR_SECOND_CTL: rd_data <= pack_ctl(ctl[1]) & MASK_SECOND;
          ADDR_THIRD_CTL:  rd_data <= pack_ctl(ctl[2]) & MASK_THIRD;
          ADDR_SECOND_CNT: rd_data <= cnt[1];
          ADDR_THIRD_CNT:  rd_data <= cnt[2];
          ADDR_SECOND_PER: rd_data <= per[1];
          ADDR_THIRD_PER:  rd_data <= per[2];
          default:         rd_data <= 16'h0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || !clk_en);

  logic wr_cnt1;
  logic int8;
  assign wr_cnt1 = bus.wr && bus.addr == ADDR_FIRST_CNT;
  assign int8 = run[0] && !ctl_wr[0] && !eff[0].clock_source_select &&
                !gate_on[0] && eff[0].prescale_select == 2'h1;

  sequence s_tick8;
    (tick[0] && int8) ##1 int8[*8];
  endsequence

  a_run_hold: assert property (
    (!ctl[0].run_enable && !wr_cnt1) |=> cnt[0] == $past(cnt[0]))
    else $error("first count moved while stopped");

  a_idle_hold: assert property (
    (idle_mode && ctl[0].idle_stop && !wr_cnt1) |=> $stable(cnt[0]))
    else $error("first count moved in idle with stop set");

  a_gate_block: assert property (
    (gate_on[0] && !s2[0]) |-> !tick[0])
    else $error("tick while gate inactive");

  a_prescale_div: assert property (
    s_tick8 |-> tick[0])
    else $error("divide by eight period wrong");

  a_async_edge: assert property (
    (run[0] && ctl[0].clock_source_select && !ctl[0].ext_clock_sync &&
     ctl[0].prescale_select == 2'h0 && raw_q[0] && !raw_prev[0])
    |-> tick[0])
    else $error("async edge not counted");

  a_sync_edge: assert property (
    (run[0] && ctl[0].clock_source_select && ctl[0].ext_clock_sync &&
     $rose(pin[0])) |-> ##2 cnt_in[0])
    else $error("synchronised edge not seen two cycles later");

  a_unimpl_zero: assert property (
    (bus.rd && bus.addr == ADDR_FIRST_CTL) |=> (rd_data & ~MASK_FIRST) == 0)
    else $error("unimplemented control bit read nonzero");

  a_match_irq: assert property (
    (tick[0] && match[0] && !wr_cnt1) |=> first_irq && cnt[0] == CNT_RESET)
    else $error("first match did not wrap and interrupt");

  a_chain_irq: assert property (
    (chain && tick[1] && match32) |=> third_irq && adc_trigger && !second_irq)
    else $error("chained match not on third flag");

  a_chain_carry: assert property (
    (chain && tick[1] && !match32 && cnt[1] == 16'hFFFF && !bus.wr)
    |=> cnt[2] == $past(cnt[2]) + 16'h0001 && cnt[1] == 16'h0000)
    else $error("chained carry lost");

  a_solo_trigger: assert property (
    !$past(chain) |-> !adc_trigger)
    else $error("trigger from unchained timer");

endmodule : gts_timer_suite

/* rtl/gts_pkg.sv */
// Purpose: Shared constants and types for the general timer suite.
// Assumes: 16-bit registers on a plain strobe port, word addressed.
// Notes:   Control layouts of all three timers share one bit map.
package gts_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_TMR = 3;

  // Register word addresses.
  localparam logic [3:0] ADDR_FIRST_CTL   = 4'h0;
  localparam logic [3:0] ADDR_FIRST_CNT   = 4'h1;
  localparam logic [3:0] ADDR_FIRST_PER   = 4'h2;
  localparam logic [3:0] ADDR_SECOND_CTL  = 4'h3;
  localparam logic [3:0] ADDR_THIRD_CTL   = 4'h4;
  localparam logic [3:0] ADDR_SECOND_CNT  = 4'h5;
  localparam logic [3:0] ADDR_THIRD_CNT   = 4'h6;
  localparam logic [3:0] ADDR_SECOND_PER  = 4'h7;
  localparam logic [3:0] ADDR_THIRD_PER   = 4'h8;

  // Control bit positions.
  localparam int unsigned BIT_RUN   = 15;
  localparam int unsigned BIT_IDLE  = 13;
  localparam int unsigned BIT_GATE  = 6;
  localparam int unsigned BIT_PS_HI = 5;
  localparam int unsigned BIT_PS_LO = 4;
  localparam int unsigned BIT_CHAIN = 3;
  localparam int unsigned BIT_SYNC  = 2;
  localparam int unsigned BIT_CS    = 1;

  // Implemented bits of each control register; the rest read zero.
  localparam logic [15:0] MASK_FIRST  = 16'hA076;
  localparam logic [15:0] MASK_SECOND = 16'hA07A;
  localparam logic [15:0] MASK_THIRD  = 16'hA072;

  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] PER_RESET = 16'hFFFF;

  // Terminal prescaler counts for 1:1, 1:8, 1:64 and 1:256.
  localparam logic [7:0] PS_LAST_1   = 8'h00;
  localparam logic [7:0] PS_LAST_8   = 8'h07;
  localparam logic [7:0] PS_LAST_64  = 8'h3F;
  localparam logic [7:0] PS_LAST_256 = 8'hFF;

  typedef struct packed {
    logic       run_enable;
    logic       idle_stop;
    logic       gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic       chain_mode;
    logic       ext_clock_sync;
    logic       clock_source_select;
  } gts_ctl_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } gts_bus_s;

endpackage : gts_pkg

/* bench/gts_pin_src.sv */
// Purpose: Far-side source for the three timer pins.
// Assumes: Pins idle low and change just after a rising clock edge.
// Notes:   Each pin serves as external clock and as gate level.
`timescale 1ns/1ps
module gts_pin_src (
  input  wire logic       clock,
  output logic      [2:0] pins
);
  initial pins = 3'h0;

  // rising clock edges.
  // Rising edges are five cycles apart so the synchroniser never merges two.
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge clock);
      pins[idx] <= 1'b1;
      repeat (2) @(posedge clock);
      pins[idx] <= 1'b0;
      repeat (2) @(posedge clock);
    end
  endtask : pulse

  task automatic level(input int idx, input logic v);
    @(posedge clock);
    pins[idx] <= v;
  endtask : level
endmodule : gts_pin_src

/* bench/gts_timer_suite_tb_top.sv */
// Purpose: Self-checking bench for the timer suite.
// Assumes: Word-addressed strobe bus, read data one cycle after rd.
// Notes:   Interrupt spacing is measured in clock cycles.
`timescale 1ns/1ps
module gts_timer_suite_tb_top
  import gts_pkg::*;
;
  logic              clock;
  logic              rst;
  logic              clk_en;
  gts_bus_s          bus;
  logic [DATA_W-1:0] rd_data;
  logic              idle_mode;
  logic [2:0]        pins;
  logic              first_irq;
  logic              second_irq;
  logic              third_irq;
  logic              adc_trigger;
  logic [DATA_W-1:0] second_time_base;
  logic [DATA_W-1:0] third_time_base;
  logic              chain_on;
  int                fails;
  int                checks_done;
  int                n;
  logic [15:0]       d;
  logic [15:0]       held;

  gts_timer_suite gts_timer_suite_inst (
    .clock(clock), .rst(rst), .clk_en(clk_en), .bus(bus), .rd_data(rd_data),
    .idle_mode(idle_mode), .first_ext_clock_pin(pins[0]),
    .second_ext_clock_pin(pins[1]), .third_ext_clock_pin(pins[2]),
    .first_irq(first_irq), .second_irq(second_irq), .third_irq(third_irq),
    .adc_trigger(adc_trigger), .second_time_base(second_time_base),
    .third_time_base(third_time_base));

  gts_pin_src gts_pin_src_inst (.clock(clock), .pins(pins));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 v = rd_data;
  endtask : rd

  function automatic logic irq_of(input int w);
    case (w)
      0: return first_irq;
      1: return second_irq;
      default: return third_irq;
    endcase
  endfunction : irq_of

  // Cycles until the chosen pulse is seen, or -1 when the limit runs out.
  task automatic wait_irq(input int w, input int lim, output int c);
    c = -1;
    for (int i = 1; i <= lim; i++) begin
      @(posedge clock);
      #1;
      if (irq_of(w) === 1'b1) begin
        c = i;
        break;
      end
    end
  endtask : wait_irq

  // The trigger must stay quiet unless the pair is chained.
  always @(posedge clock) begin
    if ((adc_trigger === 1'b1 && !chain_on) ||
        (second_irq === 1'b1 && chain_on)) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, 1, 0);
    end
  end

  task automatic t_reset;
    for (int a = 0; a < 9; a++) begin
      rd(a[3:0], d);
      check(d, (a == 2 || a > 6) ? PER_RESET : 16'h0000);
    end
    rd(4'hF, d);
    check(d, 16'h0000);
  endtask : t_reset

  task automatic t_masks;
    logic [15:0] m [3];
    m = '{MASK_FIRST, MASK_SECOND, MASK_THIRD};
    for (int i = 0; i < 3; i++) begin
      logic [3:0] a;
      a = (i == 0) ? ADDR_FIRST_CTL : 4'(ADDR_SECOND_CTL + i - 1);
      wr(a, 16'h7FFF);
      rd(a, d);
      check(d, m[i] & 16'h7FFF);
      wr(a, 16'h0000);
    end
  endtask : t_masks

  task automatic t_run;
    wr(ADDR_FIRST_PER, 16'h0002);
    wr(ADDR_FIRST_CTL, 16'h8000);
    wait_irq(0, 10, n);
    wait_irq(0, 10, n);
    check(n, 3);
    wr(ADDR_FIRST_CTL, 16'h0000);
    wait_irq(0, 10, n);
    check(n, -1);
  endtask : t_run

  task automatic t_prescale;
    int div [4];
    div = '{1, 8, 64, 256};
    wr(ADDR_FIRST_PER, 16'h0000);
    // A count left above the period would run the full range first.
    wr(ADDR_FIRST_CNT, 16'h0000);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_FIRST_CTL, 16'h8000 | 16'(p << 4));
      wait_irq(0, 300, n);
      wait_irq(0, 300, n);
      check(n, div[p]);
    end
    wr(ADDR_FIRST_CTL, 16'h0000);
  endtask : t_prescale

  task automatic t_idle;
    wr(ADDR_FIRST_PER, 16'hFFFF);
    wr(ADDR_FIRST_CNT, 16'h0000);
    idle_mode <= 1'b1;
    wr(ADDR_FIRST_CTL, 16'hA000);
    repeat (10) @(posedge clock);
    rd(ADDR_FIRST_CNT, d);
    check(d, 16'h0000);
    wr(ADDR_FIRST_CTL, 16'h8000);
    repeat (10) @(posedge clock);
    rd(ADDR_FIRST_CNT, d);
    check(d, 16'h000B);
    wr(ADDR_FIRST_CTL, 16'h0000);
    idle_mode <= 1'b0;
  endtask : t_idle

  task automatic t_extern;
    wr(ADDR_FIRST_CNT, 16'h0000);
    wr(ADDR_FIRST_CTL, 16'h8046);
    gts_pin_src_inst.pulse(0, 5);
    rd(ADDR_FIRST_CNT, d);
    check(d, 16'h0005);
    wr(ADDR_FIRST_CNT, 16'h0000);
    wr(ADDR_FIRST_CTL, 16'h8002);
    gts_pin_src_inst.pulse(0, 3);
    rd(ADDR_FIRST_CNT, d);
    check(d, 16'h0003);
    wr(ADDR_FIRST_CTL, 16'h0000);
  endtask : t_extern

  task automatic t_gate;
    wr(ADDR_FIRST_CNT, 16'h0000);
    wr(ADDR_FIRST_CTL, 16'h8040);
    repeat (10) @(posedge clock);
    rd(ADDR_FIRST_CNT, d);
    check(d, 16'h0000);
    gts_pin_src_inst.level(0, 1'b1);
    repeat (19) @(posedge clock);
    gts_pin_src_inst.level(0, 1'b0);
    wait_irq(0, 8, n);
    check(n, 3);
    rd(ADDR_FIRST_CNT, d);
    check(d, 16'h0014);
    wr(ADDR_FIRST_CTL, 16'h0000);
  endtask : t_gate

  task automatic t_chain;
    chain_on = 1'b1;
    wr(ADDR_SECOND_CTL, 16'h0008);
    wr(ADDR_THIRD_CTL, 16'h8030);
    wr(ADDR_THIRD_PER, 16'h0001);
    wr(ADDR_SECOND_PER, 16'h0002);
    wr(ADDR_SECOND_CNT, 16'hFFFE);
    wr(ADDR_THIRD_CNT, 16'h0000);
    wr(ADDR_SECOND_CTL, 16'h8008);
    for (int i = 0; i < 10 && third_time_base !== 16'h0001; i++) begin
      @(posedge clock);
      #1;
    end
    check({third_time_base, second_time_base}, 32'h00010000);
    wait_irq(2, 10, n);
    check(n, 3);
    check(adc_trigger, 1'b1);
    // third idle stop halts the pair.
    wr(ADDR_THIRD_CTL, 16'h2000);
    idle_mode <= 1'b1;
    rd(ADDR_SECOND_CNT, held);
    repeat (5) @(posedge clock);
    rd(ADDR_SECOND_CNT, d);
    check(d, held);
    idle_mode <= 1'b0;
    wr(ADDR_SECOND_CTL, 16'h0000);
    wr(ADDR_THIRD_CTL, 16'h0000);
    repeat (2) @(posedge clock);
    chain_on = 1'b0;
  endtask : t_chain

  task automatic t_split;
    wr(ADDR_SECOND_PER, 16'h0001);
    wr(ADDR_SECOND_CNT, 16'h0000);
    wr(ADDR_THIRD_CNT, 16'h0000);
    wr(ADDR_SECOND_CTL, 16'h8000);
    wait_irq(1, 10, n);
    wait_irq(1, 10, n);
    check(n, 2);
    check(third_time_base, 16'h0000);
    wr(ADDR_SECOND_CTL, 16'h0000);
  endtask : t_split

  // Clock enable low must hold a running count still.
  task automatic t_freeze;
    wr(ADDR_FIRST_CNT, 16'h0000);
    wr(ADDR_FIRST_CTL, 16'h8000);
    clk_en <= 1'b0;
    repeat (10) @(posedge clock);
    clk_en <= 1'b1;
    rd(ADDR_FIRST_CNT, d);
    check(d, 16'h0001);
    wr(ADDR_FIRST_CTL, 16'h0000);
  endtask : t_freeze

  // The tests need about a thousand cycles; the watchdog allows 30000 cycles.
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    bus = '0;
    idle_mode = 1'b0;
    clk_en = 1'b1;
    chain_on = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_masks();
    t_run();
    t_prescale();
    t_idle();
    t_extern();
    t_gate();
    t_chain();
    t_split();
    t_freeze();
    report_and_stop();
  end
endmodule : gts_timer_suite_tb_top
